// File: design/lhbi_regs.svh
// Purpose: constants for the host bus interface port
// Assumes: included by bare name
// Notes: addresses are five bits, data eight
`ifndef LHBI_REGS_SVH
`define LHBI_REGS_SVH
`define LHBI_ADDR_W 5
`define LHBI_DATA_W 8
`define LHBI_SER_BITS 16
`define LHBI_SER_HALF 8
`define LHBI_CMD_READ_BIT 7
`define LHBI_ADDR_RST 5'h00
`define LHBI_DATA_RST 8'h00
`define LHBI_IRQ_SRCS 3
`endif

// File: design/lhbi_pkg.sv
// Purpose: types for the host bus interface port
// Assumes: nothing
// Notes: host modes and serial frame states
package lhbi_pkg;
  typedef enum logic [1:0] {
    LHBI_HOST_HW = 2'b00,
    LHBI_HOST_SERIAL = 2'b01,
    LHBI_HOST_SEP = 2'b10,
    LHBI_HOST_DATA_STB = 2'b11
  } lhbi_host_t;
  typedef enum logic [1:0] {
    LHBI_SER_IDLE = 2'b00,
    LHBI_SER_CMD = 2'b01,
    LHBI_SER_DATA = 2'b10
  } lhbi_ser_t;
endpackage

// File: design/lhbi_sync_if.sv
// Purpose: carries synchronised pin levels and edges from the edge finder
// Assumes: one clock domain
// Notes: levels plus one-cycle rise and fall pulses
`timescale 1ns/100ps
`default_nettype none
interface lhbi_sync_if;
  logic [6:0] lvl;
  logic [6:0] rise;
  logic [6:0] fall;
  modport src (output lvl, rise, fall);
  modport dst (input lvl, rise, fall);
endinterface
`default_nettype wire

// File: design/lhbi_sync.sv
// Purpose: two-flop synchroniser and edge finder for host pins
// Assumes: pins are asynchronous to MCLK
// Notes: edges are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module lhbi_sync (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // raw pins
  input wire logic [6:0] pins,
  // synchronised view
  lhbi_sync_if.src sy
);
  logic [6:0] s1_reg;
  logic [6:0] s2_reg;
  logic [6:0] s3_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 7'h7F;
      s2_reg <= 7'h7F;
      s3_reg <= 7'h7F;
    end else if (ce) begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign sy.lvl = s2_reg;
  assign sy.rise = ce ? (s2_reg & ~s3_reg) : 7'h00;
  assign sy.fall = ce ? (~s2_reg & s3_reg) : 7'h00;
endmodule
`default_nettype wire

// File: design/lhbi_host_port.sv
// Purpose: serial and parallel host access port with ready, ack and interrupt
// Assumes: all host pins asynchronous to MCLK; register store outside
// Notes: pin edges seen about three MCLK cycles late
// Summary of operation
// [R1] serial out launched on edge chosen by select
// [R2] serial in sampled on every rising clock
// [R3] write: output off 8 cycles, low 8
// [R4] read: output off only during command byte
// [R5] transfer is command byte plus data byte
// [R6] latch low address bits on latch fall
// [R7] host keeps address strobe high non-multiplexed
// [R8] latch low address bits on strobe fall
// [R9] host holds read strobe low for reads
// [R10] direction select low writes, high reads
// [R11] write data taken on write strobe rise
// [R12] write data taken on data strobe rise
// [R13] read data driven after data strobe fall, released on rise
// [R14] separate address latched on data strobe fall
// [R15] ready high when cycle may complete
// [R16] acknowledge low when data valid or taken
// [R17] open-drain low interrupt from three sources
// [R18] hardware mode ignores all host inputs
// [R19] format select: low separate, high multiplexed
// [R20] host frames each access with chip select
`include "lhbi_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module lhbi_host_port (
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic CE,
  // mode straps
  input wire lhbi_pkg::lhbi_host_t HOST_MODE,
  input wire logic BUS_FORMAT_SELECT,
  input wire logic CLOCK_EDGE_SELECT,
  // host control pins
  input wire logic CS_N,
  input wire logic SCLK_ALE_ADDRESS_STROBE_N,
  input wire logic RD_N_RW,
  input wire logic SERIAL_IN_LINE_WR_N_DATA_STROBE_N,
  // host data pins
  input wire logic [4:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  // host status pins
  output logic SERIAL_OUT_LINE,
  output logic SERIAL_OUT_OE,
  output logic RDY_ACK,
  output logic INT_N_OUT,
  output logic INT_N_OE,
  // register store side
  input wire logic [2:0] IRQ_SRC,
  input wire logic [7:0] RD_DATA,
  output logic [4:0] REG_ADDR,
  output logic [7:0] WR_DATA,
  output logic WR_STB,
  output logic RD_STB
);
  lhbi_sync_if sy ();
  logic [6:0] pins;
  logic [7:0] din_s1_reg;
  logic [7:0] din_reg;
  logic [4:0] ain_s1_reg;
  logic [4:0] ain_reg;
  logic hw;
  logic ser;
  logic cs_act;
  logic sclk_r;
  logic sclk_f;
  logic launch;
  lhbi_pkg::lhbi_ser_t ser_reg;
  logic [4:0] bit_reg;
  logic [7:0] sh_reg;
  logic rd_cyc_reg;
  logic [7:0] tx_reg;
  logic access_reg;
  logic [7:0] bus_data;
  // bit 0 select, 1 shift clock or latch, 2 read or direction, 3 serial in or strobe
  assign pins = {3'h7, SERIAL_IN_LINE_WR_N_DATA_STROBE_N, RD_N_RW, SCLK_ALE_ADDRESS_STROBE_N,
    CS_N};
  lhbi_sync u_sync (
    .clk(MCLK),
    .arst_n(ARST_N),
    .ce(CE),
    .pins(pins),
    .sy(sy)
  );
  // bus pins sampled twice as well
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      din_s1_reg <= `LHBI_DATA_RST;
      din_reg <= `LHBI_DATA_RST;
      ain_s1_reg <= `LHBI_ADDR_RST;
      ain_reg <= `LHBI_ADDR_RST;
    end else if (CE) begin
      din_s1_reg <= DATA_IN;
      din_reg <= din_s1_reg;
      ain_s1_reg <= ADDR_IN;
      ain_reg <= ain_s1_reg;
    end
  end
  assign hw = (HOST_MODE == lhbi_pkg::LHBI_HOST_HW); // see [R18]
  assign ser = (HOST_MODE == lhbi_pkg::LHBI_HOST_SERIAL);
  assign cs_act = !hw && !sy.lvl[0]; // see [R20]
  assign sclk_r = ser && cs_act && sy.rise[1];
  assign sclk_f = ser && cs_act && sy.fall[1];
  assign launch = CLOCK_EDGE_SELECT ? sclk_f : sclk_r; // see [R1]
  // mux for bus data: multiplexed uses AD lines on same pins
  assign bus_data = din_reg;
  // serial frame sequencer
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ser_reg <= lhbi_pkg::LHBI_SER_IDLE;
      bit_reg <= 5'h00;
      sh_reg <= `LHBI_DATA_RST;
      rd_cyc_reg <= 1'b0;
    end else if (CE) begin
      if (!ser || !cs_act) begin
        ser_reg <= lhbi_pkg::LHBI_SER_IDLE;
        bit_reg <= 5'h00;
      end else if (sclk_r) begin // see [R2]
        sh_reg <= {sh_reg[6:0], sy.lvl[3]};
        bit_reg <= bit_reg + 5'h01;
        case (ser_reg)
          lhbi_pkg::LHBI_SER_IDLE: begin
            ser_reg <= lhbi_pkg::LHBI_SER_CMD;
          end
          lhbi_pkg::LHBI_SER_CMD: begin
            if (bit_reg == 5'(`LHBI_SER_HALF - 1)) begin // see [R5]
              ser_reg <= lhbi_pkg::LHBI_SER_DATA;
              rd_cyc_reg <= sh_reg[5];
            end
          end
          lhbi_pkg::LHBI_SER_DATA: begin
            if (bit_reg == 5'(`LHBI_SER_BITS - 1)) begin
              ser_reg <= lhbi_pkg::LHBI_SER_IDLE;
            end
          end
          default: begin
            ser_reg <= lhbi_pkg::LHBI_SER_IDLE;
          end
        endcase
      end
    end
  end
  // serial output line
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SERIAL_OUT_LINE <= 1'b0;
      SERIAL_OUT_OE <= 1'b0;
      tx_reg <= `LHBI_DATA_RST;
    end else if (CE) begin
      if (ser_reg != lhbi_pkg::LHBI_SER_DATA || !cs_act || RD_STB) begin
        SERIAL_OUT_OE <= 1'b0; // see [R3] [R4]
        tx_reg <= RD_DATA;
      end else if (launch) begin
        SERIAL_OUT_OE <= 1'b1;
        SERIAL_OUT_LINE <= rd_cyc_reg ? tx_reg[7] : 1'b0; // see [R3] [R4]
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end
  // parallel address, strobes and handshake
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_ADDR <= `LHBI_ADDR_RST;
      WR_DATA <= `LHBI_DATA_RST;
      WR_STB <= 1'b0;
      RD_STB <= 1'b0;
      DATA_OUT <= `LHBI_DATA_RST;
      DATA_OE <= 1'b0;
      RDY_ACK <= 1'b1;
      access_reg <= 1'b0;
    end else if (CE) begin
      WR_STB <= 1'b0;
      RD_STB <= 1'b0;
      if (ser) begin
        RDY_ACK <= 1'b1;
        DATA_OE <= 1'b0;
        if (sclk_r && ser_reg == lhbi_pkg::LHBI_SER_CMD && bit_reg == 5'(`LHBI_SER_HALF - 1)) begin
          REG_ADDR <= {sh_reg[3:0], sy.lvl[3]};
          RD_STB <= sh_reg[5];
        end
        if (sclk_r && ser_reg == lhbi_pkg::LHBI_SER_DATA && bit_reg == 5'(`LHBI_SER_BITS - 1) &&
            !rd_cyc_reg) begin
          WR_DATA <= {sh_reg[6:0], sy.lvl[3]};
          WR_STB <= 1'b1;
        end
      end else if (!cs_act) begin
        DATA_OE <= 1'b0;
        access_reg <= 1'b0;
        RDY_ACK <= 1'b1; // see [R15] [R16]
      end else if (HOST_MODE == lhbi_pkg::LHBI_HOST_SEP) begin
        if (BUS_FORMAT_SELECT && sy.fall[1]) begin
          REG_ADDR <= bus_data[4:0]; // see [R6] [R19]
        end else if (!BUS_FORMAT_SELECT && (sy.fall[2] || sy.fall[3])) begin
          REG_ADDR <= ain_reg; // see [R7] [R19]
        end
        if (sy.fall[2]) begin // see [R9]
          RD_STB <= 1'b1;
          RDY_ACK <= 1'b0; // see [R15]
        end else if (!sy.lvl[2] && !access_reg) begin
          DATA_OUT <= RD_DATA;
          DATA_OE <= 1'b1;
          access_reg <= 1'b1;
          RDY_ACK <= 1'b1; // see [R15]
        end else if (sy.rise[2]) begin
          DATA_OE <= 1'b0;
          access_reg <= 1'b0;
        end
        if (sy.rise[3]) begin
          WR_DATA <= bus_data; // see [R11]
          WR_STB <= 1'b1;
        end
      end else begin
        if (BUS_FORMAT_SELECT && sy.fall[1]) begin
          REG_ADDR <= bus_data[4:0]; // see [R8] [R19]
        end else if (!BUS_FORMAT_SELECT && sy.fall[3]) begin
          REG_ADDR <= ain_reg; // see [R14]
        end
        if (sy.fall[3] && sy.lvl[2]) begin // see [R10]
          RD_STB <= 1'b1;
        end
        if (sy.rise[3]) begin
          RDY_ACK <= 1'b1;
          DATA_OE <= 1'b0;
          if (!sy.lvl[2]) begin
            WR_DATA <= bus_data; // see [R12]
            WR_STB <= 1'b1;
          end
        end else if (!sy.lvl[3] && RDY_ACK && !sy.fall[3]) begin
          if (sy.lvl[2]) begin
            DATA_OUT <= RD_DATA; // see [R13]
            DATA_OE <= 1'b1;
          end
          RDY_ACK <= 1'b0; // see [R16]
        end
      end
    end
  end
  // interrupt output, open drain
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      INT_N_OUT <= 1'b0;
      INT_N_OE <= 1'b0;
    end else if (CE) begin
      INT_N_OUT <= 1'b0;
      INT_N_OE <= |IRQ_SRC; // see [R17]
    end
  end
  a_write_out_low: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (SERIAL_OUT_OE && !rd_cyc_reg) |-> !SERIAL_OUT_LINE) // see [R3]
    else $error("serial write output not low");
  a_cmd_out_off: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (ser_reg == lhbi_pkg::LHBI_SER_CMD) |=> (!SERIAL_OUT_OE || ser_reg == lhbi_pkg::LHBI_SER_DATA)) // see [R4]
    else $error("serial output driven during command");
  a_int_follows: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (CE && IRQ_SRC != 3'h0) |=> INT_N_OE) // see [R17]
    else $error("interrupt not raised");
  a_hw_quiet: assert property (@(posedge MCLK) disable iff (!ARST_N)
    hw |=> (!WR_STB && !RD_STB && !SERIAL_OUT_OE)) // see [R18]
    else $error("host activity in hardware mode");
  a_frame_len: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (ser_reg == lhbi_pkg::LHBI_SER_DATA) |-> (bit_reg >= 5'(`LHBI_SER_HALF))) // see [R5]
    else $error("data phase before command byte done");
  a_strobe_write: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (CE && HOST_MODE == lhbi_pkg::LHBI_HOST_DATA_STB && cs_act && sy.rise[3] && !sy.lvl[2])
    |=> (WR_STB && WR_DATA == $past(bus_data))) // see [R12]
    else $error("data strobe write not taken");
  a_sep_write: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (CE && HOST_MODE == lhbi_pkg::LHBI_HOST_SEP && cs_act && sy.rise[3]) |=> WR_STB) // see [R11]
    else $error("write strobe not taken");
  sequence s_ready_pulse;
    !RDY_ACK ##1 RDY_ACK;
  endsequence
  a_ready_drop: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (CE && HOST_MODE == lhbi_pkg::LHBI_HOST_SEP && cs_act && sy.fall[2]) |=> s_ready_pulse) // see [R15]
    else $error("ready handshake wrong");
endmodule
`default_nettype wire

// File: test/lhbi_host_model.sv
// Purpose: host model driving the port's pins
// Assumes: pins change on the falling edge of clk
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module lhbi_host_model (
  // clock and device answers
  input wire logic clk,
  input wire logic edge_sel,
  input wire logic so,
  input wire logic so_oe,
  input wire logic rdy,
  input wire logic [7:0] bus,
  // host pins
  output logic cs_n,
  output logic sc,
  output logic rw,
  output logic st,
  output logic [4:0] a,
  output logic [7:0] d,
  // captured results
  output logic [15:0] oe_v,
  output logic [15:0] ln_v,
  output logic [7:0] rd_v,
  output logic rdy_v
);
  initial begin
    {cs_n, sc, rw, st, a, d} = {4'hF, 13'h0000};
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one parallel access, either strobe style
  task automatic par(input logic sep, input logic w, input logic mux, input logic [4:0] ad,
    input logic [7:0] dt);
    int i;
    cs_n = 1'b0;
    if (!sep) rw = ~w;
    if (mux) begin
      d = {3'h7, ad};
      wt(2);
      sc = 1'b0;
      wt(4);
    end else a = ad;
    if (w) d = dt;
    else d = ~d;
    wt(2);
    if (sep && !w) rw = 1'b0;
    else st = 1'b0;
    wt(5);
    for (i = 0; i < 20 && (sep ? !rdy : rdy); i++) wt(1);
    rd_v = bus;
    rdy_v = rdy;
    if (sep && !w) rw = 1'b1;
    else st = 1'b1;
    wt(5);
    {sc, rw, cs_n} = 3'h7;
    d = ~d;
    a = ~a;
    wt(4);
  endtask
  // one serial frame of sixteen shift clocks
  task automatic ser(input logic [7:0] cmd, input logic [7:0] dt);
    int i;
    cs_n = 1'b0;
    for (i = 0; i < 16; i++) begin
      sc = 1'b0;
      st = i < 8 ? cmd[7 - i] : dt[15 - i];
      wt(4);
      oe_v[i] = so_oe;
      ln_v[i] = so;
      if (edge_sel && i > 7) rd_v[15 - i] = so;
      sc = 1'b1;
      wt(4);
      if (!edge_sel && i > 7) rd_v[15 - i] = so;
    end
    sc = 1'b0;
    wt(4);
    cs_n = 1'b1;
    st = ~st;
    wt(2);
    sc = 1'b1;
    wt(4);
  endtask
endmodule
`default_nettype wire

// File: test/liu_host_bus_interface_tb_top.sv
// Purpose: self-checking bench for the host port
// Assumes: register store modelled by a read value of 3'h6 over the register address
// Notes: strobes are counted and captured as they pulse
`timescale 1ns/100ps
`default_nettype none
module liu_host_bus_interface_tb_top;
  logic mclk, arst_n, edge_sel, fmt, cs_n, sc, rw, st, d_oe, so, so_oe, rdy, i_o, i_oe, ws, rs;
  logic rdy_v;
  lhbi_pkg::lhbi_host_t mode;
  logic [2:0] irq;
  logic [4:0] a, r_addr, wa, ra;
  logic [7:0] d, d_o, w_d, wd, bus, rd_v;
  logic [15:0] oe_v, ln_v;
  int bad_count, n_checks, wn, rn, n;
  assign bus = d_oe ? d_o : d;
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  lhbi_host_port lhbi_host_port_i (.MCLK(mclk), .ARST_N(arst_n), .CE(1'b1), .HOST_MODE(mode),
    .BUS_FORMAT_SELECT(fmt), .CLOCK_EDGE_SELECT(edge_sel), .CS_N(cs_n),
    .SCLK_ALE_ADDRESS_STROBE_N(sc),
    .RD_N_RW(rw), .SERIAL_IN_LINE_WR_N_DATA_STROBE_N(st), .ADDR_IN(a), .DATA_IN(bus),
    .DATA_OUT(d_o), .DATA_OE(d_oe), .SERIAL_OUT_LINE(so), .SERIAL_OUT_OE(so_oe),
    .RDY_ACK(rdy), .INT_N_OUT(i_o), .INT_N_OE(i_oe), .IRQ_SRC(irq),
    .RD_DATA({3'h6, r_addr}),
    .REG_ADDR(r_addr), .WR_DATA(w_d), .WR_STB(ws), .RD_STB(rs));
  lhbi_host_model lhbi_host_model_i (.clk(mclk), .edge_sel(edge_sel), .so(so), .so_oe(so_oe),
    .rdy(rdy), .bus(bus), .cs_n(cs_n), .sc(sc), .rw(rw), .st(st), .a(a), .d(d),
    .oe_v(oe_v), .ln_v(ln_v), .rd_v(rd_v), .rdy_v(rdy_v));
  always @(posedge mclk) begin
    if (ws === 1'b1) begin
      wa <= r_addr;
      wd <= w_d;
      wn <= wn + 1;
    end
    if (rs === 1'b1) begin
      ra <= r_addr;
      rn <= rn + 1;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    {arst_n, edge_sel, fmt, irq} = 6'h00;
    mode = lhbi_pkg::LHBI_HOST_HW;
    {wn, rn, bad_count, n_checks} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk({15'h0000, rdy}, 16'h0001);
    // separate and data strobes, each bus format
    for (int m = 0; m < 4; m++) begin
      mode = m[1] ? lhbi_pkg::LHBI_HOST_SEP : lhbi_pkg::LHBI_HOST_DATA_STB;
      fmt = m[0];
      n = wn;
      lhbi_host_model_i.par(m[1], 1'b1, m[0], 5'h15, 8'h5A);
      chk(16'(wn), 16'(n + 1));
      chk(16'(wa), 16'h0015);
      chk(16'(wd), 16'h005A);
      chk({15'h0000, rdy_v}, {15'h0000, m[1]});
      n = rn;
      lhbi_host_model_i.par(m[1], 1'b0, m[0], 5'h0A, 8'h00);
      chk(16'(rn), 16'(n + 1));
      chk(16'(ra), 16'h000A);
      chk(16'(rd_v), 16'h00CA);
      chk({15'h0000, rdy_v}, {15'h0000, m[1]});
    end
    $display("test parallel done");
    mode = lhbi_pkg::LHBI_HOST_SERIAL;
    fmt = 1'b0;
    for (int c = 0; c < 2; c++) begin
      edge_sel = c[0];
      n = wn;
      lhbi_host_model_i.ser(8'h13, 8'h96);
      chk(16'(wn), 16'(n + 1));
      chk({3'h0, wa, wd}, 16'h1396);
      chk(oe_v & 16'hFEFE, 16'hFE00);
      chk(ln_v & 16'hFE00, 16'h0000);
      n = rn;
      lhbi_host_model_i.ser(8'h4C, 8'h00);
      chk(16'(rn), 16'(n + 1));
      chk(16'(ra), 16'h000C);
      chk(16'(rd_v), 16'h00CC);
      chk(oe_v & 16'hFEFE, 16'hFE00);
    end
    $display("test serial done");
    mode = lhbi_pkg::LHBI_HOST_HW;
    n = wn;
    lhbi_host_model_i.par(1'b0, 1'b1, 1'b0, 5'h03, 8'h11);
    chk(16'(wn), 16'(n));
    $display("test hardware mode done");
    for (int i = 0; i < 8; i++) begin
      irq = i[2:0];
      repeat (4) @(negedge mclk);
      chk({14'h0000, i_oe, i_o}, {14'h0000, (i != 0), 1'b0});
    end
    $display("test interrupt done");
    close_out();
  end
endmodule
`default_nettype wire
